// ### core/anw_pkg.sv
package anw_pkg;

	// ****************************************
	// Register map, one aligned word each
	// ****************************************
	localparam int unsigned ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_DATA = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_FEATURE = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_ADDR0 = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_ADDR1 = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_ADDR2 = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_DEVHEAD = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_CMD = 8'h1C;
	localparam logic [ADDR_W-1:0] OFF_ERROR = 8'h20;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ****************************************
	// Command codes and result values
	// ****************************************
	localparam logic [7:0] CMD_WRITE_NOERASE = 8'h38;
	localparam logic [7:0] CMD_POWER_QUERY = 8'hE5;
	localparam logic [7:0] PWR_RES_STANDBY = 8'h00;
	localparam logic [7:0] PWR_RES_IDLE = 8'h80;
	localparam logic [7:0] PWR_RES_ACTIVE = 8'hFF;
	localparam logic [1:0] PWR_MODE_STANDBY = 2'h0;
	localparam logic [1:0] PWR_MODE_IDLE = 2'h1;

	// ****************************************
	// Field positions and sizes
	// ****************************************
	localparam int unsigned DH_LBA_BIT = 6;
	localparam int unsigned DH_DEV_BIT = 4;
	localparam logic [7:0] COUNT_ZERO = 8'h00;
	localparam logic [8:0] SECTORS_MAX = 9'h100;
	localparam logic [7:0] WORD_LAST = 8'hFF;
	localparam logic [7:0] SECT_FIRST = 8'h01;
	localparam logic [3:0] HEAD_FIRST = 4'h0;

	typedef struct packed {
		logic bsy;
		logic drdy;
		logic df;
		logic rsv4;
		logic drq;
		logic rsv2;
		logic rsv1;
		logic err;
	} anw_status_t;

	typedef struct packed {
		logic rsv7;
		logic rsv6;
		logic rsv5;
		logic idnf;
		logic rsv3;
		logic abrt;
		logic rsv1;
		logic med;
	} anw_error_t;

	typedef struct packed {
		logic [15:0] data;
		logic [27:0] addr;
		logic lba_mode;
		logic last;
	} anw_media_t;

	typedef enum logic [1:0] {
		ST_READY,
		ST_CHECK,
		ST_XFER,
		ST_COMMIT
	} anw_state_t;

endpackage

// ### core/anw_sync.sv
`timescale 1ns/1ps
module anw_sync
	import anw_pkg::*;
#(
	parameter int unsigned WIDTH = 1
)
(
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// ****************************************
	// Two-stage synchronisers
	// ****************************************
	logic [WIDTH-1:0] meta_r;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_ff @(posedge clk_sys_in or negedge arst_n_in)
			begin
				if (!arst_n_in)
				begin
					meta_r[i] <= 1'b0;
					sync_out[i] <= 1'b0;
				end
				else
				begin
					meta_r[i] <= async_in[i];
					sync_out[i] <= meta_r[i];
				end
			end
		end
	endgenerate

endmodule

// ### core/anw_core.sv
`timescale 1ns/1ps
module anw_core
	import anw_pkg::*;
#(
	parameter bit CFA_SUPPORTED = 1'b1,
	parameter bit PM_SUPPORTED = 1'b1,
	parameter bit DEV_ID = 1'b0,
	parameter logic [28:0] CAPACITY = 29'h00100000,
	parameter logic [15:0] CYLINDERS = 16'h0400,
	parameter logic [4:0] HEADS = 5'h10,
	parameter logic [7:0] SPT = 8'h3F
)
(
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic media_fault_in,
	input wire logic media_error_in,
	input wire logic geometry_valid_in,
	input wire logic [1:0] power_mode_in,
	output anw_media_t media_word_out,
	output logic media_valid_out
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic reg_known(input logic [ADDR_W-1:0] a);
		reg_known = (a == OFF_DATA) || (a == OFF_FEATURE) || (a == OFF_COUNT) ||
			(a == OFF_ADDR0) || (a == OFF_ADDR1) || (a == OFF_ADDR2) ||
			(a == OFF_DEVHEAD) || (a == OFF_CMD) || (a == OFF_ERROR);
	endfunction

	function automatic logic [7:0] power_result(input logic [1:0] mode);
		if (mode == PWR_MODE_STANDBY)
			power_result = PWR_RES_STANDBY;
		else if (mode == PWR_MODE_IDLE)
			power_result = PWR_RES_IDLE;
		else
			power_result = PWR_RES_ACTIVE;
	endfunction

	// ****************************************
	// Synchronised pins
	// ****************************************
	logic [4:0] pins_s;
	logic fault_s;
	logic media_err_s;
	logic geom_ok_s;
	logic [1:0] pwr_mode_s;

	anw_sync #(.WIDTH(5)) u_sync (
		.clk_sys_in(clk_sys_in),
		.arst_n_in(arst_n_in),
		.async_in({media_fault_in, media_error_in, geometry_valid_in, power_mode_in}),
		.sync_out(pins_s)
	);

	assign fault_s = pins_s[4];
	assign media_err_s = pins_s[3];
	assign geom_ok_s = pins_s[2];
	assign pwr_mode_s = pins_s[1:0];

	// ****************************************
	// AXI4-Lite write channels
	// ****************************************
	logic aw_held_r;
	logic w_held_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic wr_fire;

	assign wr_fire = aw_held_r && w_held_r && !bvalid_r;

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			aw_held_r <= 1'b0;
			awready_r <= 1'b1;
			awaddr_r <= '0;
		end
		else if (s_axi_awvalid_in && awready_r)
		begin
			aw_held_r <= 1'b1;
			awready_r <= 1'b0;
			awaddr_r <= s_axi_awaddr_in;
		end
		else if (wr_fire)
		begin
			aw_held_r <= 1'b0;
			awready_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			w_held_r <= 1'b0;
			wready_r <= 1'b1;
			wdata_r <= '0;
			wstrb_r <= '0;
		end
		else if (s_axi_wvalid_in && wready_r)
		begin
			w_held_r <= 1'b1;
			wready_r <= 1'b0;
			wdata_r <= s_axi_wdata_in;
			wstrb_r <= s_axi_wstrb_in;
		end
		else if (wr_fire)
		begin
			w_held_r <= 1'b0;
			wready_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_r <= 1'b1;
			bresp_r <= reg_known(awaddr_r) ? RESP_OKAY : RESP_DECERR;
		end
		else if (s_axi_bready_in)
			bvalid_r <= 1'b0;
	end

	assign s_axi_awready_out = awready_r;
	assign s_axi_wready_out = wready_r;
	assign s_axi_bvalid_out = bvalid_r;
	assign s_axi_bresp_out = bresp_r;

	// ****************************************
	// Task file and command decode
	// ****************************************
	anw_state_t state_r;
	logic [7:0] feature_r;
	logic [7:0] count_r;
	logic [7:0] addr0_r;
	logic [7:0] addr1_r;
	logic [7:0] addr2_r;
	logic [7:0] devhead_r;
	logic [7:0] cmd_r;
	logic [8:0] remain_r;
	logic [7:0] word_r;
	anw_error_t error_r;
	logic drdy_r;
	logic df_r;
	anw_status_t status;
	logic lane0;
	logic tf_write;
	logic cmd_go;
	logic data_go;
	logic lba_mode;
	logic [27:0] cur_addr;
	logic [8:0] sect_total;
	logic [28:0] lba_end;
	logic chs_bad;
	logic range_bad;
	logic id_fail;
	logic [27:0] next_addr;
	logic commit_ok;

	assign lane0 = wstrb_r[0];
	// Task-file writes are ignored while a command owns the registers.
	assign tf_write = wr_fire && lane0 && (state_r == ST_READY);
	assign cmd_go = tf_write && (awaddr_r == OFF_CMD) && (devhead_r[DH_DEV_BIT] == DEV_ID);
	assign data_go = wr_fire && (awaddr_r == OFF_DATA) && (wstrb_r[1:0] == 2'b11) &&
		(state_r == ST_XFER);

	assign lba_mode = devhead_r[DH_LBA_BIT];
	assign cur_addr = {devhead_r[3:0], addr2_r, addr1_r, addr0_r};
	assign sect_total = (count_r == COUNT_ZERO) ? SECTORS_MAX : {1'b0, count_r};
	assign lba_end = {1'b0, cur_addr} + {20'h00000, sect_total};
	// Only the starting CHS address is range checked; a run past the last cylinder is not.
	assign chs_bad = (addr0_r == COUNT_ZERO) || (addr0_r > SPT) ||
		({1'b0, devhead_r[3:0]} >= HEADS) || ({addr2_r, addr1_r} >= CYLINDERS);
	assign range_bad = lba_mode ? (lba_end > CAPACITY) : chs_bad;
	assign id_fail = range_bad || (!lba_mode && !geom_ok_s);
	assign commit_ok = (state_r == ST_COMMIT) && !media_err_s && !fault_s;

	always_comb
	begin
		next_addr = cur_addr + 28'h0000001;
		if (!lba_mode)
		begin
			next_addr = {devhead_r[3:0], addr2_r, addr1_r, addr0_r + SECT_FIRST};
			if (addr0_r >= SPT)
			begin
				next_addr = {devhead_r[3:0] + 4'h1, addr2_r, addr1_r, SECT_FIRST};
				if ({1'b0, devhead_r[3:0]} >= HEADS - 5'h01)
					next_addr = {HEAD_FIRST, {addr2_r, addr1_r} + 16'h0001, SECT_FIRST};
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			feature_r <= '0;
			count_r <= '0;
			addr0_r <= '0;
			addr1_r <= '0;
			addr2_r <= '0;
			devhead_r <= '0;
		end
		else if (tf_write)
		begin
			unique case (awaddr_r)
				OFF_FEATURE: feature_r <= wdata_r[7:0];
				OFF_COUNT: count_r <= wdata_r[7:0];
				OFF_ADDR0: addr0_r <= wdata_r[7:0];
				OFF_ADDR1: addr1_r <= wdata_r[7:0];
				OFF_ADDR2: addr2_r <= wdata_r[7:0];
				OFF_DEVHEAD: devhead_r <= wdata_r[7:0];
				default: ;
			endcase
		end
		else if (commit_ok)
		begin
			// A failed sector leaves the registers on it, so the host sees where it stopped.
			{devhead_r[3:0], addr2_r, addr1_r, addr0_r} <= next_addr;
		end
		else if ((state_r == ST_CHECK) && (cmd_r == CMD_POWER_QUERY) && PM_SUPPORTED)
			count_r <= power_result(pwr_mode_s);
	end

	// ****************************************
	// Command engine
	// ****************************************
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			state_r <= ST_READY;
			cmd_r <= '0;
			remain_r <= '0;
			word_r <= '0;
		end
		else
		begin
			unique case (state_r)
				ST_READY:
				begin
					if (cmd_go)
					begin
						cmd_r <= wdata_r[7:0];
						state_r <= ST_CHECK;
					end
				end
				ST_CHECK:
				begin
					state_r <= ST_READY;
					if ((cmd_r == CMD_WRITE_NOERASE) && CFA_SUPPORTED && !id_fail)
					begin
						remain_r <= sect_total;
						word_r <= '0;
						state_r <= ST_XFER;
					end
				end
				ST_XFER:
				begin
					if (data_go)
					begin
						word_r <= word_r + 8'h01;
						if (word_r == WORD_LAST)
							state_r <= ST_COMMIT;
					end
				end
				ST_COMMIT:
				begin
					// Data goes to the media as written; no erase pass is made first.
					remain_r <= remain_r - 9'h001;
					if (!commit_ok || (remain_r == 9'h001))
						state_r <= ST_READY;
					else
						state_r <= ST_XFER;
				end
			endcase
		end
	end

	// ****************************************
	// Error and status bits
	// ****************************************
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			error_r <= '0;
			drdy_r <= 1'b1;
			df_r <= 1'b0;
		end
		else if (cmd_go)
		begin
			error_r <= '0;
			df_r <= 1'b0;
			drdy_r <= 1'b1;
		end
		else if (state_r == ST_CHECK)
		begin
			drdy_r <= 1'b1;
			if (cmd_r == CMD_WRITE_NOERASE)
			begin
				error_r.abrt <= !CFA_SUPPORTED;
				error_r.idnf <= CFA_SUPPORTED && id_fail;
			end
			else if (cmd_r == CMD_POWER_QUERY)
			begin
				error_r.abrt <= !PM_SUPPORTED;
				df_r <= 1'b0;
			end
			else
				error_r.abrt <= 1'b1;
		end
		else if ((state_r == ST_COMMIT) && !commit_ok)
		begin
			error_r.med <= media_err_s;
			error_r.abrt <= fault_s;
			df_r <= fault_s;
		end
	end

	always_comb
	begin
		status = '0;
		status.bsy = (state_r == ST_CHECK) || (state_r == ST_COMMIT);
		status.drdy = drdy_r;
		status.df = df_r;
		status.drq = (state_r == ST_XFER);
		status.err = |error_r;
	end

	// ****************************************
	// Media word output
	// ****************************************
	anw_media_t media_r;
	logic media_valid_r;

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			media_r <= '0;
			media_valid_r <= 1'b0;
		end
		else
		begin
			media_valid_r <= data_go;
			if (data_go)
			begin
				media_r.data <= wdata_r[15:0];
				media_r.addr <= cur_addr;
				media_r.lba_mode <= lba_mode;
				media_r.last <= (word_r == WORD_LAST);
			end
		end
	end

	assign media_word_out = media_r;
	assign media_valid_out = media_valid_r;

	// ****************************************
	// AXI4-Lite read channel
	// ****************************************
	logic arready_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic [7:0] rd_byte;

	always_comb
	begin
		rd_byte = '0;
		unique case (s_axi_araddr_in)
			OFF_COUNT: rd_byte = count_r;
			OFF_ADDR0: rd_byte = addr0_r;
			OFF_ADDR1: rd_byte = addr1_r;
			OFF_ADDR2: rd_byte = addr2_r;
			OFF_DEVHEAD: rd_byte = devhead_r;
			OFF_CMD: rd_byte = status;
			OFF_ERROR: rd_byte = error_r;
			default: rd_byte = '0;
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end
		else if (s_axi_arvalid_in && arready_r)
		begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= {24'h000000, rd_byte};
			rresp_r <= reg_known(s_axi_araddr_in) ? RESP_OKAY : RESP_DECERR;
		end
		else if (rvalid_r && s_axi_rready_in)
		begin
			rvalid_r <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	assign s_axi_arready_out = arready_r;
	assign s_axi_rvalid_out = rvalid_r;
	assign s_axi_rdata_out = rdata_r;
	assign s_axi_rresp_out = rresp_r;

endmodule

// ### testbench/anw_core_sva.sv
`timescale 1ns/1ps
// ****************************************
// Bus and media port checks
// ****************************************
module anw_core_sva
	import anw_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic [1:0] s_axi_rresp_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic media_valid_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!arst_n_in);
	sequence seq_wr_take;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
	endsequence
	sequence seq_rd_take;
		s_axi_arvalid_in && s_axi_arready_out;
	endsequence
	chk_write_answer: assert property (seq_wr_take |-> ##2 s_axi_bvalid_out)
		else $error("write answer late");
	chk_write_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
		else $error("write answer dropped");
	chk_ready_back: assert property ($rose(s_axi_bvalid_out) |-> s_axi_awready_out)
		else $error("write channel not free");
	chk_read_answer: assert property (seq_rd_take |=> s_axi_rvalid_out && !s_axi_arready_out)
		else $error("read answer late");
	chk_read_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> $stable(s_axi_rdata_out))
		else $error("read data moved");
	chk_read_cause: assert property ($rose(s_axi_rvalid_out) |-> $past(s_axi_arvalid_in))
		else $error("read answer without request");
	chk_unmapped_rd: assert property (s_axi_arvalid_in && s_axi_arready_out
		&& s_axi_araddr_in > OFF_ERROR |=> s_axi_rresp_out == RESP_DECERR)
		else $error("unmapped read not refused");
	chk_byte_only: assert property (seq_rd_take ##1 s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_media_pulse: assert property (media_valid_out |=> !media_valid_out)
		else $error("media pulse too long");
	chk_media_cause: assert property (media_valid_out |-> s_axi_bvalid_out)
		else $error("media word without data write");
endmodule
bind anw_core anw_core_sva anw_core_sva_inst (.clk_sys_in, .arst_n_in, .s_axi_awvalid_in,
	.s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in,
	.s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
	.s_axi_rvalid_out, .s_axi_rready_in, .media_valid_out);

// ### testbench/anw_media_model.sv
`timescale 1ns/1ps
// ****************************************
// Media side stand-in
// ****************************************
module anw_media_model
	import anw_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic media_valid_in,
	input wire logic err_en_in,
	input wire logic fault_en_in,
	input wire logic geo_ok_in,
	input wire logic [1:0] mode_in,
	output logic media_error_out,
	output logic media_fault_out,
	output logic geometry_valid_out,
	output logic [1:0] power_mode_out
);
	logic [7:0] words_r;
	logic flaw_r;
	// The flaw shows only after half a sector, so it must be judged at commit.
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			words_r <= 8'h00;
		else if (media_valid_in)
			words_r <= words_r + 8'h01;
	end
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			flaw_r <= 1'b0;
		else if (!err_en_in)
			flaw_r <= 1'b0;
		else if (media_valid_in && words_r == 8'h7F)
			flaw_r <= 1'b1;
	end
	assign media_error_out = flaw_r;
	assign media_fault_out = fault_en_in;
	assign geometry_valid_out = geo_ok_in;
	assign power_mode_out = mode_in;
endmodule

// ### testbench/anw_core_tb.sv
`timescale 1ns/1ps
module anw_core_tb;
	import anw_pkg::*;
	logic clk_sys_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic awr, wr_rdy, bv, arr, rv, mv, m_err, m_flt, m_geo;
	logic [1:0] br_q, rr_q;
	logic [3:0] ws = 4'hF;
	logic err_en = 1'b0, flt_en = 1'b0, geo_ok = 1'b1;
	logic [1:0] bresp, rresp, pm, mode = 2'h0;
	logic [7:0] awa = 8'h00, ara = 8'h00, st, c;
	logic [31:0] wd = 32'h0, rdat;
	logic [27:0] lba;
	logic [7:0] pq [4] = '{PWR_RES_STANDBY, PWR_RES_IDLE, PWR_RES_ACTIVE, PWR_RES_ACTIVE};
	logic [45:0] exp_q[$];
	anw_media_t mw;
	int fail_count = 0, tests_run = 0, cyc = 0;
	always #50 clk_sys_in = ~clk_sys_in;
	anw_core anw_core_inst (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
		.s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
		.s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_rdy),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
		.s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
		.s_axi_rdata_out(rdat), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
		.s_axi_rready_in(rry), .media_fault_in(m_flt), .media_error_in(m_err),
		.geometry_valid_in(m_geo), .power_mode_in(pm), .media_word_out(mw), .media_valid_out(mv));
	anw_media_model anw_media_model_inst (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
		.media_valid_in(mv), .err_en_in(err_en), .fault_en_in(flt_en), .geo_ok_in(geo_ok),
		.mode_in(mode), .media_error_out(m_err), .media_fault_out(m_flt),
		.geometry_valid_out(m_geo), .power_mode_out(pm));
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string m);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic ad, dd;
		@(posedge clk_sys_in);
		awa <= a;
		wd <= {16'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		ad = 1'b0;
		dd = 1'b0;
		while (!(ad && dd))
		begin
			@(posedge clk_sys_in);
			ad = ad | awr;
			dd = dd | wr_rdy;
			awv <= !ad;
			wv <= !dd;
		end
		do @(posedge clk_sys_in); while (!bv);
		// Ready comes late on purpose, so the answer must stand while it waits.
		bry <= 1'b1;
		@(posedge clk_sys_in);
		br_q = bresp;
		bry <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys_in);
		ara <= a;
		arv <= 1'b1;
		do @(posedge clk_sys_in); while (!arr);
		arv <= 1'b0;
		do @(posedge clk_sys_in); while (!rv);
		rry <= 1'b1;
		@(posedge clk_sys_in);
		d = rdat[7:0];
		rr_q = rresp;
		rry <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string m);
		logic [7:0] d;
		rd(a, d);
		check(d, e, m);
	endtask
	task automatic poll;
		int n;
		n = 0;
		do
		begin
			rd(OFF_CMD, st);
			n++;
		end
		while (st[7] && n < 50);
	endtask
	task automatic setup(input logic [27:0] a, input logic lm, input logic [7:0] cnt);
		lba = a;
		wr(OFF_COUNT, 16'(cnt));
		wr(OFF_ADDR0, 16'(a[7:0]));
		wr(OFF_ADDR1, 16'(a[15:8]));
		wr(OFF_ADDR2, 16'(a[23:16]));
		wr(OFF_DEVHEAD, {8'h00, 1'b1, lm, 2'b10, a[27:24]});
	endtask
	task automatic cmd(input logic [7:0] code);
		wr(OFF_CMD, 16'(code));
		poll();
	endtask
	task automatic sector(input logic [27:0] k);
		logic [15:0] w;
		for (int i = 0; i < 256; i++)
		begin
			w = 16'($urandom);
			exp_q.push_back({w, lba + k, 1'b1, i == 255});
			wr(OFF_DATA, w);
		end
	endtask
	always @(posedge clk_sys_in)
	begin
		cyc++;
		if (mv)
		begin
			tests_run++;
			if (exp_q.size() == 0 || mw !== exp_q.pop_front())
			begin
				fail_count++;
				$display("CHECK FAILED at %0t: media word", $time);
			end
		end
		if (cyc == 40000)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: timeout", $time);
			give_verdict();
		end
	end
	initial
	begin
		void'($urandom(41553));
		repeat (16) @(posedge clk_sys_in);
		arst_n_in <= 1'b1;
		rdchk(OFF_CMD, 8'h40, "reset status");
		rdchk(OFF_ERROR, 8'h00, "reset error");
		rdchk(8'h24, 8'h00, "unmapped");
		check(8'(rr_q), 8'(RESP_DECERR), "unmapped read resp");
		wr(8'h24, 16'h0000);
		check(8'(br_q), 8'(RESP_DECERR), "unmapped write resp");
		$display("test reset done");
		for (int m = 0; m < 4; m++)
		begin
			mode <= 2'(m);
			repeat (4) @(posedge clk_sys_in);
			cmd(CMD_POWER_QUERY);
			check(st, 8'h40, "query status");
			rdchk(OFF_COUNT, pq[m], "query result");
		end
		mode <= 2'h0;
		wr(OFF_DEVHEAD, 16'h0010);
		cmd(CMD_POWER_QUERY);
		rdchk(OFF_COUNT, PWR_RES_ACTIVE, "other device");
		ws <= 4'h0;
		wr(OFF_COUNT, 16'h0055);
		ws <= 4'hF;
		rdchk(OFF_COUNT, PWR_RES_ACTIVE, "strobe off");
		$display("test power query done");
		c = 8'($urandom);
		if (c == CMD_WRITE_NOERASE || c == CMD_POWER_QUERY)
			c = 8'h00;
		wr(OFF_DEVHEAD, 16'h0000);
		cmd(c);
		check(st, 8'h41, "bad code status");
		rdchk(OFF_ERROR, 8'h04, "bad code error");
		setup(28'($urandom_range(32'h000FFFFE)), 1'b1, 8'h01);
		cmd(CMD_WRITE_NOERASE);
		check(st, 8'h48, "data request");
		check(8'(br_q), 8'(RESP_OKAY), "write resp");
		sector(28'h0);
		poll();
		check(st, 8'h40, "write done");
		lba = lba + 28'h1;
		rdchk(OFF_ADDR0, lba[7:0], "next address");
		rdchk(OFF_ADDR1, lba[15:8], "next address");
		$display("test write done");
		err_en <= 1'b1;
		setup(lba, 1'b1, 8'h01);
		cmd(CMD_WRITE_NOERASE);
		sector(28'h0);
		poll();
		check(st, 8'h41, "media status");
		rdchk(OFF_ERROR, 8'h01, "media error");
		rdchk(OFF_ADDR0, lba[7:0], "failing address");
		err_en <= 1'b0;
		flt_en <= 1'b1;
		setup(lba, 1'b1, 8'h01);
		cmd(CMD_WRITE_NOERASE);
		sector(28'h0);
		poll();
		check(st, 8'h61, "fault status");
		rdchk(OFF_ERROR, 8'h04, "fault error");
		flt_en <= 1'b0;
		$display("test write errors done");
		setup(28'h0100000, 1'b1, 8'h01);
		cmd(CMD_WRITE_NOERASE);
		check(st, 8'h41, "range status");
		rdchk(OFF_ERROR, 8'h10, "range error");
		geo_ok <= 1'b0;
		setup(28'h0000001, 1'b0, 8'h01);
		cmd(CMD_WRITE_NOERASE);
		rdchk(OFF_ERROR, 8'h10, "no geometry");
		geo_ok <= 1'b1;
		$display("test address errors done");
		setup(28'h0000010, 1'b1, 8'h00);
		cmd(CMD_WRITE_NOERASE);
		sector(28'h0);
		sector(28'h1);
		poll();
		check(st, 8'h48, "count zero");
		arst_n_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		arst_n_in <= 1'b1;
		rdchk(OFF_CMD, 8'h40, "second reset");
		check(8'(exp_q.size()), 8'h00, "words left");
		$display("test long count done");
		give_verdict();
	end
endmodule
